// File: hw/smp_map.vh
// Constants for the serial motor command parser
`ifndef SMP_MAP_VH
`define SMP_MAP_VH

// ----------------------------------------
// Timing
// ----------------------------------------
`define SMP_CLK_HZ       10000000
`define SMP_BAUD_MIN     2000
`define SMP_BAUD_MAX     60000
// Start bit plus seven zero data bits of the start byte
`define SMP_RUN_BITS     8
`define SMP_RUN_MIN_CYC  ((`SMP_RUN_BITS * `SMP_CLK_HZ) / `SMP_BAUD_MAX)
`define SMP_RUN_MAX_CYC  ((`SMP_RUN_BITS * `SMP_CLK_HZ) / `SMP_BAUD_MIN)
`define SMP_CNT_W        16

// ----------------------------------------
// Command layout
// ----------------------------------------
`define SMP_START_BYTE   8'h80
`define SMP_START_BIT    7
`define SMP_DIR_BIT      0
`define SMP_MNUM_LSB     1
`define SMP_MNUM_MSB     6
`define SMP_MNUM_ALL     6'h00
`define SMP_SPEED_OFF    7'h00
`define SMP_TGT_W        10

// ----------------------------------------
// Feedback modes
// ----------------------------------------
`define SMP_FB_NONE      2'h0
`define SMP_FB_POS       2'h1
`define SMP_FB_SPD       2'h2

`endif

// File: hw/smp_sync.v
// Two-flop synchroniser for a bundle of asynchronous inputs
`timescale 1ns/1ps

module smp_sync #(
   parameter         W       = 1,
   parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
   // Clock and reset
   input  wire         clk_i,
   input  wire         rst_n_i,
   // Data
   input  wire [W-1:0] d_i,
   output wire [W-1:0] q_o
);

   genvar g;
   generate
      for (g = 0; g < W; g = g + 1) begin : g_bit
         reg meta_q;
         reg sync_q;
         always @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               meta_q <= RST_VAL[g];
               sync_q <= RST_VAL[g];
            end else begin
               meta_q <= d_i[g];
               sync_q <= meta_q;
            end
         end
         assign q_o[g] = sync_q;
      end
   endgenerate

endmodule // smp_sync

// File: hw/smp_parser.v
// Auto-baud serial receiver and four-byte motor command parser
//
// Contract
// [RL1] Characters are 8 data bits, no parity, one stop
// [RL2] Bit rate learnt alone, 2000 to 60000 baud
// [RL3] Sender drives line non-inverted, low means zero
// [RL4] Any byte with bit 7 set restarts command
// [RL5] Sender keeps top bit clear after start byte
// [RL6] Start byte 0x80 opens every command
// [RL7] Wrong device type: ignore until next start
// [RL8] Third byte bit 0: one forward, zero back
// [RL9] Act only on motor zero or own number
// [RL10] Each controller owns distinct number 1 to 63
// [RL11] Fourth byte: seven-bit speed, zero off, 7F full
// [RL12] Position mode: zero reverse holds, forward unlocks loop
// [RL13] Sender holds line idle high around reset
// [RL14] Sender waits 100 ms after reset release
// [RL15] Reset low 2 us gives power-up state
// [RL16] Position mode uses ten-bit position value
// [RL17] Framing error drops byte and current command
// [RL18] Outputs change together after all four bytes
`timescale 1ns/1ps
`include "smp_map.vh"

module smp_parser #(
   parameter integer          RUN_MAX_CYC = `SMP_RUN_MAX_CYC,
   // Device type code; the value is arbitrary
   parameter [6:0]            DEV_TYPE    = 7'h2A
) (
   // Clock and reset
   input  wire                  clk_sys_i,
   input  wire                  rst_n_i,
   // Serial line
   input  wire                  rxd_i,
   // Configuration
   input  wire [5:0]            mnum_cfg_i,
   input  wire [1:0]            fb_mode_i,
   // Motor command
   output wire                  dir_o,
   output wire [6:0]            speed_o,
   output wire                  cmd_stb_o,
   output wire                  hold_zero_o,
   output wire                  pid_off_o,
   output wire [`SMP_TGT_W-1:0] pos_tgt_o,
   // Status
   output wire                  baud_lock_o,
   output wire                  frame_err_o
);

   // ----------------------------------------
   // Constants and states
   // ----------------------------------------
   // Counts are worked out as integers, then cut to the counter width
   localparam integer          RUN_MIN_I = `SMP_RUN_MIN_CYC;
   localparam [`SMP_CNT_W-1:0] RUN_MIN   = RUN_MIN_I[`SMP_CNT_W-1:0];
   localparam [`SMP_CNT_W-1:0] RUN_MAX   = RUN_MAX_CYC[`SMP_CNT_W-1:0];
   localparam [`SMP_CNT_W-1:0] ONE       = 16'h0001;

   localparam [5:0] R_IDLE = 6'h01;
   localparam [5:0] R_MEAS = 6'h02;
   localparam [5:0] R_MSTP = 6'h04;
   localparam [5:0] R_STRT = 6'h08;
   localparam [5:0] R_DATA = 6'h10;
   localparam [5:0] R_STOP = 6'h20;

   localparam [3:0] P_WAIT = 4'h1;
   localparam [3:0] P_TYPE = 4'h2;
   localparam [3:0] P_MNUM = 4'h4;
   localparam [3:0] P_SPD  = 4'h8;

   // ----------------------------------------
   // Decoding
   // ----------------------------------------
   function mnum_hit;
      input [5:0] num;
      input [5:0] own;
      begin
         mnum_hit = (num == `SMP_MNUM_ALL) || (num == own);
      end
   endfunction

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   wire       rxd_s;
   wire [1:0] fb_s;
   wire [5:0] mnum_s;

   // Line resets to idle high so no false start edge appears
   smp_sync #(
      .W       (9),
      .RST_VAL (9'h100)
   ) u_sync (
      .clk_i   (clk_sys_i),
      .rst_n_i (rst_n_i),
      .d_i     ({rxd_i, fb_mode_i, mnum_cfg_i}),
      .q_o     ({rxd_s, fb_s, mnum_s})
   );

   // ----------------------------------------
   // Receiver registers
   // ----------------------------------------
   reg [5:0]            rx_st_q, rx_st_d;
   reg [`SMP_CNT_W-1:0] cnt_q, cnt_d;
   reg [`SMP_CNT_W-1:0] bit_q, bit_d;
   reg [2:0]            bidx_q, bidx_d;
   reg [7:0]            shf_q, shf_d;
   reg [7:0]            byte_q, byte_d;
   reg                  vld_q, vld_d;
   reg                  ferr_q, ferr_d;
   reg                  lock_q, lock_d;
   reg                  prev_q;

   wire                  fall_w;
   wire [`SMP_CNT_W-1:0] half_w;
   wire [`SMP_CNT_W-1:0] half_end_w;
   wire [`SMP_CNT_W-1:0] bit_end_w;
   wire [`SMP_CNT_W-1:0] mstp_end_w;

   assign fall_w     = prev_q & ~rxd_s;
   assign half_w     = {1'b0, bit_q[`SMP_CNT_W-1:1]};
   assign half_end_w = half_w - ONE;
   assign bit_end_w  = bit_q - ONE;
   // Middle of the stop bit after the high bit 7 of the start byte
   assign mstp_end_w = bit_q + half_w - ONE;

   // ----------------------------------------
   // Receiver next state
   // ----------------------------------------
   always @* begin
      rx_st_d = rx_st_q;
      cnt_d   = cnt_q + ONE;
      bit_d   = bit_q;
      bidx_d  = bidx_q;
      shf_d   = shf_q;
      byte_d  = byte_q;
      vld_d   = 1'b0;
      ferr_d  = 1'b0;
      lock_d  = lock_q;
      case (rx_st_q)
         R_IDLE: begin
            cnt_d = {`SMP_CNT_W{1'b0}};
            if (fall_w) begin
               // Unlocked: time the low run of a start byte
               rx_st_d = lock_q ? R_STRT : R_MEAS; // RL2
            end
         end
         R_MEAS: begin
            if (!rxd_s) begin
               if (cnt_q >= RUN_MAX) begin
                  // Too slow for any legal rate
                  rx_st_d = R_IDLE; // RL2
               end
            end else if (cnt_q >= RUN_MIN) begin
               // Eight bit times low: period is the run over 8
               bit_d   = {3'b000, cnt_q[`SMP_CNT_W-1:3]}; // RL2
               cnt_d   = {`SMP_CNT_W{1'b0}};
               rx_st_d = R_MSTP;
            end else begin
               rx_st_d = R_IDLE;
            end
         end
         R_MSTP: begin
            if (cnt_q == mstp_end_w) begin
               rx_st_d = R_IDLE;
               if (rxd_s) begin
                  byte_d = `SMP_START_BYTE; // RL6
                  vld_d  = 1'b1;
                  lock_d = 1'b1; // RL2
               end
            end
         end
         R_STRT: begin
            if (cnt_q == half_end_w) begin
               cnt_d  = {`SMP_CNT_W{1'b0}};
               bidx_d = 3'h0;
               // A start bit that is high again was a glitch
               rx_st_d = rxd_s ? R_IDLE : R_DATA; // RL3
            end
         end
         R_DATA: begin
            if (cnt_q == bit_end_w) begin
               cnt_d  = {`SMP_CNT_W{1'b0}};
               // Low level is a zero, LSB first
               shf_d  = {rxd_s, shf_q[7:1]}; // RL1 RL3
               bidx_d = bidx_q + 3'h1;
               if (bidx_q == 3'h7) begin
                  rx_st_d = R_STOP; // RL1
               end
            end
         end
         R_STOP: begin
            if (cnt_q == bit_end_w) begin
               rx_st_d = R_IDLE;
               if (rxd_s) begin
                  byte_d = shf_q; // RL1
                  vld_d  = 1'b1;
               end else begin
                  // Lost framing may mean a new rate: relearn it
                  ferr_d = 1'b1; // RL17
                  lock_d = 1'b0;
               end
            end
         end
         default: begin
            rx_st_d = R_IDLE;
         end
      endcase
   end

   // ----------------------------------------
   // Receiver registers update
   // ----------------------------------------
   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rx_st_q <= R_IDLE; // RL15
         cnt_q   <= 16'h0000;
         bit_q   <= 16'h0000;
         bidx_q  <= 3'h0;
         shf_q   <= 8'h00;
         byte_q  <= 8'h00;
         vld_q   <= 1'b0;
         ferr_q  <= 1'b0;
         lock_q  <= 1'b0;
         prev_q  <= 1'b1;
      end else begin
         rx_st_q <= rx_st_d;
         cnt_q   <= cnt_d;
         bit_q   <= bit_d;
         bidx_q  <= bidx_d;
         shf_q   <= shf_d;
         byte_q  <= byte_d;
         vld_q   <= vld_d;
         ferr_q  <= ferr_d;
         lock_q  <= lock_d;
         prev_q  <= rxd_s;
      end
   end

   // ----------------------------------------
   // Command parser
   // ----------------------------------------
   reg [3:0] ps_q, ps_d;
   reg       dir_pend_q, dir_pend_d;
   reg       commit_w;

   always @* begin
      ps_d       = ps_q;
      dir_pend_d = dir_pend_q;
      commit_w   = 1'b0;
      if (ferr_q) begin
         ps_d = P_WAIT; // RL17
      end else if (vld_q) begin
         if (byte_q[`SMP_START_BIT]) begin
            // Any start byte abandons a half-done command
            ps_d = P_TYPE; // RL4 RL6
         end else begin
            case (ps_q)
               P_TYPE: begin
                  ps_d = (byte_q[6:0] == DEV_TYPE) ? P_MNUM
                                                   : P_WAIT; // RL7
               end
               P_MNUM: begin
                  dir_pend_d = byte_q[`SMP_DIR_BIT]; // RL8
                  ps_d = mnum_hit(byte_q[`SMP_MNUM_MSB:`SMP_MNUM_LSB],
                                  mnum_s) ? P_SPD : P_WAIT; // RL9 RL10
               end
               P_SPD: begin
                  commit_w = 1'b1; // RL18
                  ps_d     = P_WAIT;
               end
               default: begin
                  ps_d = P_WAIT; // RL7
               end
            endcase
         end
      end
   end

   // ----------------------------------------
   // Command outputs
   // ----------------------------------------
   reg                  dir_q;
   reg [6:0]            speed_q;
   reg                  stb_q;
   reg                  hold_q;
   reg                  pidoff_q;
   reg [`SMP_TGT_W-1:0] tgt_q;
   reg                  lock_o_q;
   reg                  ferr_o_q;

   wire       pos_w, zero_w;
   wire [6:0] spd_w;

   assign spd_w  = byte_q[6:0];
   assign pos_w  = (fb_s == `SMP_FB_POS);
   assign zero_w = (spd_w == `SMP_SPEED_OFF);

   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ps_q       <= P_WAIT; // RL15
         dir_pend_q <= 1'b0;
         dir_q      <= 1'b0;
         speed_q    <= 7'h00;
         stb_q      <= 1'b0;
         hold_q     <= 1'b0;
         pidoff_q   <= 1'b0;
         tgt_q      <= 10'h000;
         lock_o_q   <= 1'b0;
         ferr_o_q   <= 1'b0;
      end else begin
         ps_q       <= ps_d;
         dir_pend_q <= dir_pend_d;
         stb_q      <= commit_w;
         lock_o_q   <= lock_q;
         ferr_o_q   <= ferr_q;
         if (commit_w) begin
            // All fields load in one edge, never a mix
            dir_q    <= dir_pend_q; // RL8 RL18
            speed_q  <= spd_w; // RL11
            hold_q   <= pos_w & zero_w & ~dir_pend_q; // RL12
            pidoff_q <= pos_w & zero_w & dir_pend_q; // RL12
            // Stretch 7 bits over the full 10-bit position scale
            tgt_q    <= {spd_w, spd_w[6:4]}; // RL16
         end
      end
   end

   assign dir_o       = dir_q;
   assign speed_o     = speed_q;
   assign cmd_stb_o   = stb_q;
   assign hold_zero_o = hold_q;
   assign pid_off_o   = pidoff_q;
   assign pos_tgt_o   = tgt_q;
   assign baud_lock_o = lock_o_q;
   assign frame_err_o = ferr_o_q;

endmodule // smp_parser

// File: verif/smp_props.sv
// Checker for the motor command outputs of the parser
`timescale 1ns/1ps
module smp_props (
   // Clock and reset
   input wire logic       clk_sys_i,
   input wire logic       rst_n_i,
   // Inputs
   input wire logic       rxd_i,
   input wire logic [5:0] mnum_cfg_i,
   input wire logic [1:0] fb_mode_i,
   // Outputs
   input wire logic       dir_o,
   input wire logic [6:0] speed_o,
   input wire logic       cmd_stb_o,
   input wire logic       hold_zero_o,
   input wire logic       pid_off_o,
   input wire logic [9:0] pos_tgt_o,
   input wire logic       baud_lock_o,
   input wire logic       frame_err_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);

   property p_stb_pulse;
      cmd_stb_o |=> !cmd_stb_o;
   endproperty
   a_stb_pulse: assert property (p_stb_pulse)
      else $error("command strobe longer than one cycle");
   property p_ferr_pulse;
      frame_err_o |=> !frame_err_o;
   endproperty
   a_ferr_pulse: assert property (p_ferr_pulse)
      else $error("framing pulse longer than one cycle");
   // Past reset guard: the first edge after release still sees reset values
   property p_out_hold;
      !cmd_stb_o && $past(rst_n_i) |-> $stable({dir_o, speed_o, pos_tgt_o});
   endproperty
   a_out_hold: assert property (p_out_hold)
      else $error("outputs changed without a command");
   property p_hold;
      cmd_stb_o |-> hold_zero_o == (fb_mode_i == 2'h1 && !dir_o
                                    && speed_o == 7'h00);
   endproperty
   a_hold: assert property (p_hold)
      else $error("hold position flag wrong");
   property p_pid;
      cmd_stb_o |-> pid_off_o == (fb_mode_i == 2'h1 && dir_o
                                  && speed_o == 7'h00);
   endproperty
   a_pid: assert property (p_pid)
      else $error("loop off flag wrong");
   property p_tgt;
      cmd_stb_o |-> pos_tgt_o == {speed_o, speed_o[6:4]};
   endproperty
   a_tgt: assert property (p_tgt)
      else $error("position target not taken from speed");
   property p_unlock;
      frame_err_o |-> ##[0:3] !baud_lock_o;
   endproperty
   a_unlock: assert property (p_unlock)
      else $error("rate lock kept after framing error");
   property p_locked;
      cmd_stb_o |-> baud_lock_o;
   endproperty
   a_locked: assert property (p_locked)
      else $error("command accepted without rate lock");
endmodule // smp_props

bind smp_parser smp_props i_props (
   .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .rxd_i(rxd_i),
   .mnum_cfg_i(mnum_cfg_i), .fb_mode_i(fb_mode_i), .dir_o(dir_o),
   .speed_o(speed_o), .cmd_stb_o(cmd_stb_o), .hold_zero_o(hold_zero_o),
   .pid_off_o(pid_off_o), .pos_tgt_o(pos_tgt_o),
   .baud_lock_o(baud_lock_o), .frame_err_o(frame_err_o)
);

// File: verif/smp_host.sv
// Serial command sender standing in for the main controller
`timescale 1ns/1ps
module smp_host #(
   parameter int BIT_CYC = 180
) (
   input  wire logic clk_i,
   output logic      rxd_o
);
   initial rxd_o = 1'b1;
   // Bits change on falling edges, away from the receiver's sampling edge
   task automatic send(input logic [7:0] b, input logic stop_ok);
      logic [9:0] f;
      f = {stop_ok, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(negedge clk_i);
         rxd_o = f[i];
         repeat (BIT_CYC - 1) @(negedge clk_i);
      end
      @(negedge clk_i);
      rxd_o = 1'b1;
   endtask
   task automatic cmd(input logic [7:0] t, input logic [7:0] b3,
                      input logic [7:0] b4);
      send(8'h80, 1'b1);
      send(t, 1'b1);
      send(b3, 1'b1);
      send(b4, 1'b1);
   endtask
endmodule // smp_host

// File: verif/tb_top.sv
// Self-checking bench for the serial motor command parser
`timescale 1ns/1ps
module tb_top;
   typedef struct {logic [7:0] t, b3, b4; logic [1:0] fb; logic go;} smp_row_t;
   logic       clk_sys_i  = 1'b0;
   logic       rst_n_i    = 1'b0;
   logic [5:0] mnum_cfg_i = 6'h05;
   logic [1:0] fb_mode_i  = 2'h1;
   wire        rxd, dir_o, cmd_stb_o, hold_zero_o, pid_off_o;
   wire        baud_lock_o, frame_err_o;
   wire [6:0]  speed_o;
   wire [9:0]  pos_tgt_o;
   wire [19:0] outv = {dir_o, speed_o, hold_zero_o, pid_off_o, pos_tgt_o};
   int         failures = 0, checked = 0, cyc = 0, stbs = 0, ferrs = 0, n;
   logic [19:0] e = 20'h00000;
   smp_row_t   rows [6] = '{
      '{8'h2A, 8'h0B, 8'h7F, 2'h1, 1'b1},
      '{8'h2A, 8'h02, 8'h33, 2'h1, 1'b0},
      '{8'h2B, 8'h00, 8'h10, 2'h1, 1'b0},
      '{8'h2A, 8'h00, 8'h00, 2'h1, 1'b1},
      '{8'h2A, 8'h01, 8'h00, 2'h1, 1'b1},
      '{8'h2A, 8'h01, 8'h00, 2'h0, 1'b1}};

   smp_host #(.BIT_CYC(180)) i_host (.clk_i(clk_sys_i), .rxd_o(rxd));
   smp_parser i_dut (
      .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .rxd_i(rxd),
      .mnum_cfg_i(mnum_cfg_i), .fb_mode_i(fb_mode_i), .dir_o(dir_o),
      .speed_o(speed_o), .cmd_stb_o(cmd_stb_o), .hold_zero_o(hold_zero_o),
      .pid_off_o(pid_off_o), .pos_tgt_o(pos_tgt_o),
      .baud_lock_o(baud_lock_o), .frame_err_o(frame_err_o));

   always #50 clk_sys_i = ~clk_sys_i;
   // Pulses are counted here since they pass while the sender is busy
   always @(posedge clk_sys_i) begin
      cyc++;
      stbs += (cmd_stb_o === 1'b1);
      ferrs += (frame_err_o === 1'b1);
      if (cyc == 90000) begin
         failures++;
         give_verdict();
      end
   end

   function automatic logic [19:0] expv(logic d, logic [6:0] s, logic [1:0] f);
      expv = {d, s, f == 2'h1 && !d && s == 7'h00,
              f == 2'h1 && d && s == 7'h00, s, s[6:4]};
   endfunction
   task automatic cmp_out(input logic [19:0] g, input logic [19:0] x);
      checked++;
      if (g !== x) begin
         failures++;
         $display("mismatch t=%0t got %h exp %h", $time, g, x);
      end
   endtask
   task automatic cmp_cnt(input int g, input int x);
      checked++;
      if (g != x) begin
         failures++;
         $display("mismatch t=%0t got %h exp %h", $time, g, x);
      end
   endtask
   task automatic give_verdict();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic settle();
      repeat (20) @(negedge clk_sys_i);
   endtask

   initial begin
      repeat (3) @(negedge clk_sys_i);
      rst_n_i = 1'b1;
      // Short stand-in for the sender's start-up pause after reset
      repeat (50) @(negedge clk_sys_i);
      for (int i = 0; i < 6; i++) begin
         fb_mode_i = rows[i].fb;
         n = stbs;
         i_host.cmd(rows[i].t, rows[i].b3, rows[i].b4);
         settle();
         if (rows[i].go)
            e = expv(rows[i].b3[0], rows[i].b4[6:0], rows[i].fb);
         cmp_cnt(stbs - n, int'(rows[i].go));
         cmp_out(outv, e);
      end
      cmp_out({19'h00000, baud_lock_o}, 20'h00001);
      // -----------------------------------------
      // New start byte in mid-command
      // -----------------------------------------
      n = stbs;
      i_host.send(8'h80, 1'b1);
      i_host.send(8'h2A, 1'b1);
      i_host.cmd(8'h2A, 8'h0B, 8'h11);
      settle();
      cmp_cnt(stbs - n, 1);
      cmp_out(outv, expv(1'b1, 7'h11, 2'h0));
      // -----------------------------------------
      // Missing stop bit, then relearn
      // -----------------------------------------
      n = ferrs;
      i_host.send(8'h80, 1'b1);
      i_host.send(8'h2A, 1'b1);
      i_host.send(8'h0B, 1'b0);
      settle();
      cmp_cnt(ferrs - n, 1);
      cmp_out({19'h00000, baud_lock_o}, 20'h00000);
      n = stbs;
      i_host.send(8'h22, 1'b1);
      i_host.cmd(8'h2A, 8'h0B, 8'h22);
      settle();
      cmp_cnt(stbs - n, 1);
      cmp_out(outv, expv(1'b1, 7'h22, 2'h0));
      // -----------------------------------------
      // Reset in mid-run
      // -----------------------------------------
      rst_n_i = 1'b0;
      repeat (25) @(negedge clk_sys_i);
      cmp_out(outv, 20'h00000);
      cmp_out({19'h00000, baud_lock_o}, 20'h00000);
      rst_n_i = 1'b1;
      repeat (50) @(negedge clk_sys_i);
      i_host.cmd(8'h2A, 8'h0A, 8'h05);
      settle();
      cmp_out(outv, expv(1'b0, 7'h05, 2'h0));
      give_verdict();
   end
endmodule // tb_top
